// ### common/pcbcfg_pkg.sv
/*
  constants of the bridge configuration header: offsets, command fields,
  reset values and the layout of the vendor-specific register group.
  assumes dword-addressed configuration requests with four byte enables.
*/
package pcbcfg_pkg;

  localparam int            DW_W          = 32;
  localparam int            DWORD_IDX_W   = 10;
  localparam int            BE_W          = 4;

  localparam logic [11:0]   MAKER_OFF     = 12'h000;
  localparam logic [11:0]   PART_OFF      = 12'h002;
  localparam logic [11:0]   CMD_OFF       = 12'h004;
  localparam logic [11:0]   STATUS_OFF    = 12'h006;

  localparam logic [15:0]   CMD_RST       = 16'h0000;
  localparam logic [15:0]   CMD_WMASK     = 16'h0157;
  localparam int            CMD_UNUSED_HI = 15;
  localparam int            CMD_UNUSED_LO = 11;
  localparam int            CMD_INTX_BIT  = 10;
  localparam int            CMD_B2B_BIT   = 9;
  localparam int            CMD_SERR_BIT  = 8;
  localparam int            CMD_STEP_BIT  = 7;
  localparam int            CMD_PERR_BIT  = 6;
  localparam int            CMD_MWI_BIT   = 4;
  localparam int            CMD_MAST_BIT  = 2;
  localparam int            CMD_MEM_BIT   = 1;
  localparam int            CMD_IO_BIT    = 0;
  localparam int            STATUS_FLAG_BIT = 8;
  localparam int            HALF_W        = 16;

  localparam int            SYNC_W        = 4;
  localparam int            SYNC_SERR     = 0;
  localparam int            SYNC_FUND     = 1;
  localparam int            SYNC_GLOB     = 2;
  localparam int            SYNC_HOT      = 3;

  localparam int            VREG_NUM      = 5;
  localparam int            VREG_GPIO     = 0;
  localparam int            VREG_GCTL     = 1;
  localparam int            VREG_CLK      = 2;
  localparam int            VREG_ARB      = 3;
  localparam int            VREG_SIRQ     = 4;
  localparam logic [11:0]   VREG_OFF   [VREG_NUM] = '{12'h0B4, 12'h0D4, 12'h0D8, 12'h0DC, 12'h0E0};
  localparam logic [31:0]   VREG_WMASK [VREG_NUM] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h00FF_FFFF,
                                                      32'h0000_FFFF, 32'hFFFF_00FF};
  localparam logic [31:0]   VREG_MARK  [VREG_NUM] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h00FF_FFFF,
                                                      32'h0000_FFFF, 32'hFFFF_00FF};
  localparam logic [31:0]   VREG_RST   [VREG_NUM] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
                                                      32'h0000_0000, 32'h0000_0000};

endpackage : pcbcfg_pkg

// ### core/pcbcfg_sync.sv
/*
  two-flop synchroniser, one per input bit.
  assumes inputs arrive from outside the clk domain.
*/
`timescale 1ns/1ps
module pcbcfg_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_reg;
      logic stable_reg;
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          meta_reg   <= 1'b0;
          stable_reg <= 1'b0;
        end else begin
          meta_reg   <= async_in[i];
          stable_reg <= meta_reg;
        end
      end
      assign sync_out[i] = stable_reg;
    end
  endgenerate

endmodule : pcbcfg_sync

// ### core/pcbcfg_vreg.sv
/*
  one 32-bit vendor-specific configuration register with byte-lane writes.
  marked bits reset on fundamental/global/power-on reset, the others also
  on hot reset. assumes reset levels are already synchronous to clk.
*/
`timescale 1ns/1ps
module pcbcfg_vreg #(
  parameter logic [31:0] WMASK   = 32'hFFFF_FFFF,
  parameter logic [31:0] MARK    = 32'hFFFF_FFFF,
  parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        fund_rst,
  input  wire logic        hot_rst,
  input  wire logic        wr_en,
  input  wire logic [3:0]  byte_en,
  input  wire logic [31:0] wdata,
  output logic      [31:0] value
);

  genvar b;
  generate
    for (b = 0; b < 32; b++) begin : g_bit
      logic bit_reg;
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          bit_reg <= RST_VAL[b];
        end else if (fund_rst || (hot_rst && !MARK[b])) begin
          bit_reg <= RST_VAL[b];
        end else if (wr_en && byte_en[b/8] && WMASK[b]) begin
          bit_reg <= wdata[b];
        end
      end
      assign value[b] = bit_reg;
    end
  endgenerate

endmodule : pcbcfg_vreg

// ### core/pcbcfg_top.sv
/*
  configuration header of the express-to-pci bridge: identification, command,
  master parity flag and the vendor register group, reached by dword
  configuration requests. assumes one request per cycle at most from the
  express core, answered the next cycle; reset pins and serr come from pins.
*/
// Function
// - maker identification at offset 0, fixed code, writes ignored
// - part identification at offset 2, fixed code, writes ignored
// - command register at offset 4, cleared to zero on reset
// - command bits 15:11 read zero, writes discarded
// - command bit 10 interrupt mask is read-only zero
// - command bit 9 back-to-back reads zero, never used
// - bit 8 set: serr on pci bus sends error message; clear: none
// - command bit 7 stepping control hardwired zero
// - poisoned tlp sets status bit 8 only while command bit 6 set
// - poisoned data forwarded with bad parity regardless of bit 6
// - vendor group marked bits reset by fundamental, global, power-on reset
// - hot reset also clears unmarked bits and the command register
`timescale 1ns/1ps
module pcbcfg_top
  import pcbcfg_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE = 16'hA5A5, // arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h5A5A  // arbitrary value
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   fundamental_reset_in,
  input  wire logic                   global_reset_in,
  input  wire logic                   hot_reset_in,
  input  wire logic                   cfg_req_valid,
  input  wire logic                   cfg_req_write,
  input  wire logic [DWORD_IDX_W-1:0] cfg_req_dword,
  input  wire logic [BE_W-1:0]        cfg_req_byte_en,
  input  wire logic [DW_W-1:0]        cfg_req_wdata,
  output logic                        cfg_rsp_valid,
  output logic      [DW_W-1:0]        cfg_rsp_rdata,
  input  wire logic                   poisoned_tlp_in,
  input  wire logic                   pci_serr_in_n,
  output logic                        err_msg_pulse,
  output logic                        bad_parity_forward,
  output logic                        error_report_allow,
  output logic                        parity_response_allow,
  output logic                        mwi_allow,
  output logic                        master_allow,
  output logic                        memory_allow,
  output logic                        io_allow,
  output logic                        master_parity_error_flag,
  output logic      [DW_W-1:0]        pin_io_data_and_control,
  output logic      [DW_W-1:0]        general_control,
  output logic      [DW_W-1:0]        clock_gating_group,
  output logic      [DW_W-1:0]        arbitration_group,
  output logic      [DW_W-1:0]        serial_interrupt_control
);

  logic [SYNC_W-1:0]      sync_level;
  logic                   fund_rst;
  logic                   hot_rst;
  logic                   serr_level;
  logic                   serr_prev_reg;
  logic                   serr_seen;
  logic                   hit_vreg;
  logic                   wr_req;
  logic                   rd_req;
  logic                   hit_cmd;
  logic [15:0]            cmd_wmask;
  logic [15:0]            command_control_reg;
  logic                   flag_reg;
  logic                   flag_set;
  logic                   flag_clr;
  logic                   err_msg_reg;
  logic                   bad_par_reg;
  logic                   rsp_valid_reg;
  logic [DW_W-1:0]        rsp_rdata_reg;
  logic [DW_W-1:0]        rd_value;
  logic [DW_W-1:0]        vreg_value [VREG_NUM];

  // reset pins and serr into the clock domain
  pcbcfg_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({hot_reset_in, global_reset_in, fundamental_reset_in, pci_serr_in_n}),
    .sync_out (sync_level)
  );

  assign fund_rst = sync_level[SYNC_FUND] | sync_level[SYNC_GLOB];
  assign hot_rst  = fund_rst | sync_level[SYNC_HOT];

  assign wr_req    = cfg_req_valid & cfg_req_write;
  assign rd_req    = cfg_req_valid & ~cfg_req_write;
  assign hit_cmd   = (cfg_req_dword == CMD_OFF[11:2]);
  assign cmd_wmask = CMD_WMASK & {{8{cfg_req_byte_en[1]}}, {8{cfg_req_byte_en[0]}}};

  // command register, only the writable bits ever change
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      command_control_reg <= CMD_RST;
    end else if (hot_rst) begin
      command_control_reg <= CMD_RST;
    end else if (wr_req && hit_cmd) begin
      command_control_reg <= (command_control_reg & ~cmd_wmask) | (cfg_req_wdata[15:0] & cmd_wmask);
    end
  end

  // master data parity flag, write one to clear, set wins
  assign flag_set = poisoned_tlp_in & command_control_reg[CMD_PERR_BIT];
  assign flag_clr = wr_req & hit_cmd & cfg_req_byte_en[3] & cfg_req_wdata[HALF_W + STATUS_FLAG_BIT];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_reg <= 1'b0;
    end else if (hot_rst) begin
      flag_reg <= 1'b0;
    end else if (flag_set) begin
      flag_reg <= 1'b1;
    end else if (flag_clr) begin
      flag_reg <= 1'b0;
    end
  end

  // serr assertion edge into error message request
  // pin is inverted only after the flops; prev starts high so reset release gives no false edge
  assign serr_level = ~sync_level[SYNC_SERR];
  assign serr_seen  = serr_level & ~serr_prev_reg;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      serr_prev_reg <= 1'b1;
      err_msg_reg   <= 1'b0;
    end else begin
      serr_prev_reg <= serr_level;
      err_msg_reg   <= serr_seen & command_control_reg[CMD_SERR_BIT];
    end
  end

  // poisoned data always goes out with bad parity
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bad_par_reg <= 1'b0;
    end else begin
      bad_par_reg <= poisoned_tlp_in;
    end
  end

  // vendor register group
  genvar v;
  generate
    for (v = 0; v < VREG_NUM; v++) begin : g_vreg
      pcbcfg_vreg #(
        .WMASK   (VREG_WMASK[v]),
        .MARK    (VREG_MARK[v]),
        .RST_VAL (VREG_RST[v])
      ) u_vreg (
        .clk     (clk),
        .sys_rst (sys_rst),
        .fund_rst(fund_rst),
        .hot_rst (hot_rst),
        .wr_en   (wr_req && (cfg_req_dword == VREG_OFF[v][11:2])),
        .byte_en (cfg_req_byte_en),
        .wdata   (cfg_req_wdata),
        .value   (vreg_value[v])
      );
    end
  endgenerate

  // read data selection
  always_comb begin
    rd_value = '0;
    hit_vreg = 1'b0;
    if (cfg_req_dword == MAKER_OFF[11:2]) begin
      rd_value = {PART_CODE, MAKER_CODE};
    end else if (hit_cmd) begin
      rd_value = '0;
      rd_value[HALF_W + STATUS_FLAG_BIT] = flag_reg;
      rd_value[15:0] = command_control_reg;
    end
    for (int i = 0; i < VREG_NUM; i++) begin
      if (cfg_req_dword == VREG_OFF[i][11:2]) begin
        rd_value = vreg_value[i];
        hit_vreg = 1'b1;
      end
    end
  end

  // one-cycle answer to every request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid_reg <= 1'b0;
      rsp_rdata_reg <= '0;
    end else begin
      rsp_valid_reg <= cfg_req_valid;
      rsp_rdata_reg <= rd_req ? rd_value : '0;
    end
  end

  assign cfg_rsp_valid            = rsp_valid_reg;
  assign cfg_rsp_rdata            = rsp_rdata_reg;
  assign err_msg_pulse            = err_msg_reg;
  assign bad_parity_forward       = bad_par_reg;
  assign error_report_allow       = command_control_reg[CMD_SERR_BIT];
  assign parity_response_allow    = command_control_reg[CMD_PERR_BIT];
  assign mwi_allow                = command_control_reg[CMD_MWI_BIT];
  assign master_allow             = command_control_reg[CMD_MAST_BIT];
  assign memory_allow             = command_control_reg[CMD_MEM_BIT];
  assign io_allow                 = command_control_reg[CMD_IO_BIT];
  assign master_parity_error_flag = flag_reg;
  assign pin_io_data_and_control  = vreg_value[VREG_GPIO];
  assign general_control          = vreg_value[VREG_GCTL];
  assign clock_gating_group       = vreg_value[VREG_CLK];
  assign arbitration_group        = vreg_value[VREG_ARB];
  assign serial_interrupt_control = vreg_value[VREG_SIRQ];

  // checks
  a_maker_read: assert property (@(posedge clk) disable iff (sys_rst)
    rd_req && cfg_req_dword == MAKER_OFF[11:2] |=> cfg_rsp_valid && cfg_rsp_rdata[15:0] == MAKER_CODE)
    else $error("maker code wrong");

  a_part_read: assert property (@(posedge clk) disable iff (sys_rst)
    rd_req && cfg_req_dword == PART_OFF[11:2] |=> cfg_rsp_rdata[31:16] == PART_CODE)
    else $error("part code wrong");

  a_cmd_fixed_zero: assert property (@(posedge clk) disable iff (sys_rst)
    rd_req && hit_cmd |=> cfg_rsp_rdata[CMD_UNUSED_HI:CMD_UNUSED_LO] == 5'h00
      && cfg_rsp_rdata[CMD_INTX_BIT] == 1'b0 && cfg_rsp_rdata[CMD_B2B_BIT] == 1'b0
      && cfg_rsp_rdata[CMD_STEP_BIT] == 1'b0)
    else $error("fixed command bits not zero");

  a_cmd_hot_clear: assert property (@(posedge clk) disable iff (sys_rst)
    sync_level[SYNC_HOT] |=> command_control_reg == CMD_RST && !master_parity_error_flag)
    else $error("hot reset did not clear command");

  a_cmd_write_back: assert property (@(posedge clk) disable iff (sys_rst)
    wr_req && hit_cmd && cfg_req_byte_en[1] && !hot_rst ##1 rd_req && hit_cmd
      |=> cfg_rsp_rdata[CMD_SERR_BIT] == $past(cfg_req_wdata[CMD_SERR_BIT], 2))
    else $error("command write not kept");

  a_serr_message: assert property (@(posedge clk) disable iff (sys_rst)
    serr_seen |=> err_msg_pulse == $past(command_control_reg[CMD_SERR_BIT]) ##1 !err_msg_pulse)
    else $error("error message mismatch");

  a_flag_gated: assert property (@(posedge clk) disable iff (sys_rst)
    poisoned_tlp_in && !command_control_reg[CMD_PERR_BIT] && !flag_reg |=> !master_parity_error_flag)
    else $error("flag set while parity response off");

  a_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
    poisoned_tlp_in && command_control_reg[CMD_PERR_BIT] && !hot_rst |=> master_parity_error_flag)
    else $error("flag not set on poisoned tlp");

  a_bad_parity: assert property (@(posedge clk) disable iff (sys_rst)
    poisoned_tlp_in |=> bad_parity_forward)
    else $error("poisoned data not marked");

  a_vreg_fund: assert property (@(posedge clk) disable iff (sys_rst)
    fund_rst |=> general_control == VREG_RST[VREG_GCTL] && arbitration_group == VREG_RST[VREG_ARB])
    else $error("vendor group not reset");

  a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
    rd_req && !hit_cmd && !hit_vreg && cfg_req_dword != MAKER_OFF[11:2] |=> cfg_rsp_rdata == 32'h0000_0000)
    else $error("reserved offset not zero");

  a_write_answer: assert property (@(posedge clk) disable iff (sys_rst)
    wr_req |=> cfg_rsp_valid && cfg_rsp_rdata == 32'h0000_0000)
    else $error("write answer not empty");

  a_maker_write: assert property (@(posedge clk) disable iff (sys_rst)
    wr_req && cfg_req_dword == MAKER_OFF[11:2] ##1 rd_req && cfg_req_dword == MAKER_OFF[11:2]
      |=> cfg_rsp_rdata == {PART_CODE, MAKER_CODE})
    else $error("identification changed by write");

  a_cmd_fund_clear: assert property (@(posedge clk) disable iff (sys_rst)
    fund_rst |=> command_control_reg == CMD_RST && !master_parity_error_flag)
    else $error("fundamental reset did not clear command");

  a_unused_zero: assert property (@(posedge clk) disable iff (sys_rst)
    wr_req && hit_cmd |=> command_control_reg[CMD_UNUSED_HI:CMD_UNUSED_LO] == 5'h00)
    else $error("unused command bits written");

  a_intx_zero: assert property (@(posedge clk) disable iff (sys_rst)
    wr_req && hit_cmd |=> !command_control_reg[CMD_INTX_BIT])
    else $error("interrupt mask bit written");

  a_b2b_zero: assert property (@(posedge clk) disable iff (sys_rst)
    wr_req && hit_cmd |=> !command_control_reg[CMD_B2B_BIT])
    else $error("back-to-back bit written");

  a_step_zero: assert property (@(posedge clk) disable iff (sys_rst)
    wr_req && hit_cmd |=> !command_control_reg[CMD_STEP_BIT])
    else $error("stepping bit written");

  a_serr_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    !serr_seen |=> !err_msg_pulse)
    else $error("error message without serr edge");

  a_flag_clear: assert property (@(posedge clk) disable iff (sys_rst)
    flag_clr && !flag_set |=> !master_parity_error_flag)
    else $error("parity flag not cleared");

  a_bad_parity_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    !poisoned_tlp_in |=> !bad_parity_forward)
    else $error("bad parity without poisoned tlp");

endmodule : pcbcfg_top

// ### sim/pcbcfg_host.sv
/*
  express host model: issues dword configuration requests to the bridge.
  assumes callers start just after a falling clk edge; drives on that edge.
*/
`timescale 1ns/1ps
module pcbcfg_host
  import pcbcfg_pkg::*;
(
  input  wire logic                   clk,
  output logic                        cfg_req_valid,
  output logic                        cfg_req_write,
  output logic      [DWORD_IDX_W-1:0] cfg_req_dword,
  output logic      [BE_W-1:0]        cfg_req_byte_en,
  output logic      [DW_W-1:0]        cfg_req_wdata
);
  initial begin
    cfg_req_valid   = 1'b0;
    cfg_req_write   = 1'b0;
    cfg_req_dword   = '0;
    cfg_req_byte_en = '0;
    cfg_req_wdata   = '0;
  end

  // one request per cycle, held for exactly one rising edge
  task automatic xfer(input logic w, input logic [9:0] d, input logic [3:0] b, input logic [31:0] v);
    cfg_req_valid   = 1'b1;
    cfg_req_write   = w;
    cfg_req_dword   = d;
    cfg_req_byte_en = b;
    cfg_req_wdata   = v;
    @(negedge clk);
  endtask : xfer

  // released qualifiers show the inverse of the last value
  task automatic idle();
    cfg_req_valid   = 1'b0;
    cfg_req_write   = ~cfg_req_write;
    cfg_req_dword   = ~cfg_req_dword;
    cfg_req_byte_en = ~cfg_req_byte_en;
    cfg_req_wdata   = ~cfg_req_wdata;
    @(negedge clk);
  endtask : idle
endmodule : pcbcfg_host

// ### sim/tb.sv
/*
  self-checking bench of the bridge configuration header.
  assumes pcbcfg_host drives the config bus; answers checked from a queue.
*/
`timescale 1ns/1ps
module tb;
  import pcbcfg_pkg::*;
  localparam logic [15:0] MK = 16'hA5A5; // arbitrary value
  localparam logic [15:0] PT = 16'h5A5A; // arbitrary value
  logic                   clk, sys_rst, poisoned_tlp_in, pci_serr_in_n;
  logic [2:0]             rpins;
  logic                   cfg_req_valid, cfg_req_write, cfg_rsp_valid;
  logic [DWORD_IDX_W-1:0] cfg_req_dword;
  logic [BE_W-1:0]        cfg_req_byte_en;
  logic [DW_W-1:0]        cfg_req_wdata, cfg_rsp_rdata;
  logic                   err_msg_pulse, bad_parity_forward, master_parity_error_flag;
  logic [5:0]             en;
  logic [DW_W-1:0]        vport [VREG_NUM];
  logic [DW_W-1:0]        vexp [VREG_NUM];
  logic [DW_W-1:0]        q [$];
  logic [31:0]            v;
  int                     num_errors, total_checks, pe, pb;

  pcbcfg_host host (.clk(clk), .cfg_req_valid(cfg_req_valid), .cfg_req_write(cfg_req_write),
    .cfg_req_dword(cfg_req_dword), .cfg_req_byte_en(cfg_req_byte_en), .cfg_req_wdata(cfg_req_wdata));

  pcbcfg_top #(.MAKER_CODE(MK), .PART_CODE(PT)) uut (.clk(clk), .sys_rst(sys_rst),
    .fundamental_reset_in(rpins[0]), .global_reset_in(rpins[1]), .hot_reset_in(rpins[2]),
    .cfg_req_valid(cfg_req_valid), .cfg_req_write(cfg_req_write), .cfg_req_dword(cfg_req_dword),
    .cfg_req_byte_en(cfg_req_byte_en), .cfg_req_wdata(cfg_req_wdata), .cfg_rsp_valid(cfg_rsp_valid),
    .cfg_rsp_rdata(cfg_rsp_rdata), .poisoned_tlp_in(poisoned_tlp_in), .pci_serr_in_n(pci_serr_in_n),
    .err_msg_pulse(err_msg_pulse), .bad_parity_forward(bad_parity_forward),
    .error_report_allow(en[5]), .parity_response_allow(en[4]), .mwi_allow(en[3]),
    .master_allow(en[2]), .memory_allow(en[1]), .io_allow(en[0]),
    .master_parity_error_flag(master_parity_error_flag), .pin_io_data_and_control(vport[0]),
    .general_control(vport[1]), .clock_gating_group(vport[2]), .arbitration_group(vport[3]),
    .serial_interrupt_control(vport[4]));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  // answer watcher: oldest note against each answer
  always @(negedge clk) begin
    if (cfg_rsp_valid === 1'b1) begin
      check(32'(q.size() != 0), 32'h1);
      if (q.size() != 0) check(cfg_rsp_rdata, q.pop_front());
    end
  end

  task automatic rd(input logic [9:0] d, input logic [31:0] exp);
    q.push_back(exp);
    host.xfer(1'b0, d, 4'hF, $urandom);
  endtask : rd

  task automatic wr(input logic [9:0] d, input logic [3:0] b, input logic [31:0] dat);
    q.push_back(32'h0);
    host.xfer(1'b1, d, b, dat);
  endtask : wr

  // optional poisoned pulse, then count event pulses over n cycles
  task automatic watch(input logic p, input int n);
    pe = 0;
    pb = 0;
    poisoned_tlp_in = p;
    repeat (n) begin
      @(negedge clk);
      poisoned_tlp_in = 1'b0;
      pe += (err_msg_pulse === 1'b1);
      pb += (bad_parity_forward === 1'b1);
    end
  endtask : watch

  task automatic pin_rst(input int k);
    rpins[k] = 1'b1;
    repeat (4) @(negedge clk);
    rpins[k] = 1'b0;
    repeat (4) @(negedge clk);
  endtask : pin_rst

  task automatic vfill();
    for (int i = 0; i < VREG_NUM; i++) begin
      v = $urandom;
      wr(VREG_OFF[i][11:2], 4'hF, v);
      vexp[i] = v & VREG_WMASK[i];
    end
    for (int i = 0; i < VREG_NUM; i++) begin
      v = $urandom;
      wr(VREG_OFF[i][11:2], 4'b0010, v);
      vexp[i] = (vexp[i] & ~32'h0000_FF00) | (v & VREG_WMASK[i] & 32'h0000_FF00);
    end
  endtask : vfill

  task automatic vcheck();
    for (int i = 0; i < VREG_NUM; i++) rd(VREG_OFF[i][11:2], vexp[i]);
    host.idle();
    for (int i = 0; i < VREG_NUM; i++) check(vport[i], vexp[i]);
  endtask : vcheck

  task automatic set_cmd(input logic [15:0] c);
    wr(CMD_OFF[11:2], 4'b0011, {16'hFFFF, c});
    host.idle();
  endtask : set_cmd

  initial begin
    #400000;
    num_errors++;
    $display("ERROR %0t watchdog expired", $time);
    close_out();
  end

  initial begin
    sys_rst = 1'b1;
    rpins = 3'b000;
    poisoned_tlp_in = 1'b0;
    pci_serr_in_n = 1'b1;
    void'($urandom(32'he792));
    repeat (5) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    rd(MAKER_OFF[11:2], {PT, MK});
    wr(MAKER_OFF[11:2], 4'hF, $urandom);
    rd(MAKER_OFF[11:2], {PT, MK});
    rd(CMD_OFF[11:2], 32'h0);
    wr(CMD_OFF[11:2], 4'b0011, 32'h0000_FFFF);
    rd(CMD_OFF[11:2], {16'h0, CMD_WMASK});
    v = $urandom;
    wr(CMD_OFF[11:2], 4'b0011, v);
    rd(CMD_OFF[11:2], {16'h0, v[15:0] & CMD_WMASK});
    host.idle();
    check({26'h0, en}, {26'h0, v[8], v[6], v[4], v[2], v[1], v[0]});
    set_cmd(16'h0140);
    watch(1'b1, 4);
    check(32'(pb), 32'h1);
    check({31'h0, master_parity_error_flag}, 32'h1);
    rd(CMD_OFF[11:2], 32'h0100_0140);
    wr(CMD_OFF[11:2], 4'b1000, 32'h0100_0000);
    rd(CMD_OFF[11:2], 32'h0000_0140);
    host.idle();
    pci_serr_in_n = 1'b0;
    watch(1'b0, 8);
    check(32'(pe), 32'h1);
    pci_serr_in_n = 1'b1;
    watch(1'b0, 4);
    set_cmd(16'h0000);
    watch(1'b1, 4);
    check(32'(pb), 32'h1);
    check({31'h0, master_parity_error_flag}, 32'h0);
    pci_serr_in_n = 1'b0;
    watch(1'b0, 8);
    check(32'(pe), 32'h0);
    pci_serr_in_n = 1'b1;
    vfill();
    vcheck();
    for (int d = 42; d <= 63; d += 21) begin
      wr(d[9:0], 4'hF, $urandom);
      rd(d[9:0], 32'h0);
    end
    set_cmd(16'h0157);
    pin_rst(2);
    rd(CMD_OFF[11:2], 32'h0);
    vcheck();
    check({26'h0, en}, 32'h0);
    for (int k = 0; k < 2; k++) begin
      vfill();
      set_cmd(16'h0157);
      pin_rst(k);
      rd(CMD_OFF[11:2], 32'h0);
      for (int i = 0; i < VREG_NUM; i++) vexp[i] = VREG_RST[i];
      vcheck();
    end
    repeat (3) @(negedge clk);
    check(32'(q.size()), 32'h0);
    close_out();
  end
endmodule : tb
